// >>> verilog/ppp_pkg.sv
// Package: constants, codes and carrier types of the parallel programming port
package ppp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;                    // core_clk period
  localparam int ENTRY_HOLD_NS  = 100;                   // Entry pins stable after high voltage
  localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MIN_STROBE_TOGGLES = 3'h6;      // Clock pin pulses before entry
  localparam logic [2:0] ENTRY_CNT_LAST = 3'(ENTRY_HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // Strobe actions and command bytes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;                // Load address byte
  localparam logic [1:0] ACT_DATA = 2'h1;                // Load data byte
  localparam logic [1:0] ACT_CMD  = 2'h2;                // Load command byte
  localparam logic [1:0] ACT_IDLE = 2'h3;                // No action
  localparam logic [3:0] ENTRY_PINS_OK = 4'h0;           // Required entry pin pattern
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE     = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK     = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH    = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM   = 8'h11;
  localparam logic [7:0] CMD_RD_SIG      = 8'h08;
  localparam logic [7:0] CMD_RD_FUSELOCK = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH    = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM   = 8'h03;
  localparam logic [7:0] CMD_RESET_VAL   = 8'h00;        // No operation after reset
  localparam logic [7:0] BYTE_RESET_VAL  = 8'h00;        // Address and data bytes after reset
  localparam logic [7:0] BUS_IDLE_VAL    = 8'hFF;        // Bus value for unmapped reads

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_OFF, ST_ENTRY, ST_FAIL, ST_READY, ST_BUSY} ppp_state_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_ERASE_FLASH, OP_ERASE_EEPROM, OP_ERASE_LOCK, OP_PROG_FLASH,
    OP_PROG_EEPROM, OP_WR_FUSE_LOW, OP_WR_FUSE_HIGH, OP_WR_LOCK
  } ppp_op_t;

  // Read data presented by the memory arrays for the current address
  typedef struct packed {
    logic [15:0] flash_word;                             // Addressed flash word
    logic [7:0]  eeprom_byte;                            // Addressed EEPROM byte
    logic [7:0]  sig_byte;                               // Addressed signature byte
    logic [7:0]  calib_byte;                             // Addressed calibration byte
    logic [7:0]  fuse_low;                               // Fuse low byte
    logic [7:0]  fuse_high;                              // Fuse high byte
    logic [7:0]  lock_bits;                              // Lock byte
  } ppp_rdata_t;

  // Operation request towards the memory arrays
  typedef struct packed {
    logic        start;                                  // One-cycle start pulse
    ppp_op_t     op;                                     // Operation to run
    logic [15:0] addr;                                   // {address high, address low}
    logic [7:0]  wdata;                                  // Data low byte for fuse and lock
  } ppp_memreq_t;

endpackage

// >>> verilog/ppp_port.sv
// Module: parallel programming port front end with page buffer and erase sequencing
`timescale 1ns/100ps
// Function
// RULE_01: ready_busy_out low while an operation runs
// RULE_02: drive data bus only while output enable low
// RULE_03: first select picks low or high byte
// RULE_04: second select picks low or second high byte
// RULE_05: entry needs latch, action, first select low
// RULE_06: programmer toggles clock pin six times first
// RULE_07: entry pins changing in 100 ns fails entry
// RULE_08: strobe action selects address, data, command, idle
// RULE_09: address byte stored high or low by select
// RULE_10: decode write commands erase, fuse, lock, flash, EEPROM
// RULE_11: decode read commands signature, fuse, flash, EEPROM
// RULE_12: command and address retained across operations
// RULE_13: programmer reloads high address per window only
// RULE_14: programmer may skip writing erased value FF
// RULE_15: erase flash, EEPROM, then lock; fuses kept
// RULE_16: preserve fuse keeps EEPROM through chip erase
// RULE_17: programmer erases before reprogramming memories
// RULE_18: erase command plus write pulse starts erase, busy
// RULE_19: loaded words collected in a page buffer
// RULE_20: programmer loads address low, data low, data high
// RULE_21: page latch pulse stores data at word index
// RULE_22: low bits pick word, upper bits pick page
// RULE_23: programmer loads address high with select one
// RULE_24: programmer fixes clock source fuses when needed
// RULE_25: write pulse with select zero programs page
// RULE_26: flash read gives low or high byte
// RULE_27: strobe inputs captured on clock pin rising edge
module ppp_port #(
  parameter int PAGE_WORDS = 64                          // Words in one flash page
) (
  input  wire logic               core_clk,              // System clock, 50 MHz
  input  wire logic               reset_n,               // Asynchronous reset, active low
  input  wire logic               prog_voltage_high,     // High voltage present on reset pin
  input  wire logic               strobe_clock_pin,      // Clock pin used as load strobe
  input  wire logic               output_enable_n,       // Bus output enable, active low
  input  wire logic               write_strobe_n,        // Write pulse, active low
  input  wire logic               page_latch_strobe,     // Page latch pulse
  input  wire logic               strobe_action_bit0,    // Strobe action bit 0
  input  wire logic               strobe_action_bit1,    // Strobe action bit 1
  input  wire logic               byte_select_first,     // First byte select
  input  wire logic               byte_select_second,    // Second byte select
  input  wire logic [7:0]         data_in,               // Data bus input side
  output logic [7:0]              data_out,              // Data bus output side
  output logic                    data_oe_n,             // Low while the bus is driven
  output logic                    ready_busy_out,        // 1 ready, 0 busy
  output logic                    prog_mode,             // High while in programming mode
  input  wire logic               eeprom_preserve_fuse,  // 1 when the preserve fuse is programmed
  input  wire ppp_pkg::ppp_rdata_t mem_rdata,            // Read data from the arrays
  output ppp_pkg::ppp_memreq_t    mem_req,               // Operation request to the arrays
  input  wire logic               mem_done,              // Array finished the current operation
  input  wire logic [$clog2(PAGE_WORDS)-1:0] pb_rd_idx,  // Page buffer read index
  output logic [15:0]             pb_rd_word             // Page buffer word, registered
);

  localparam int WB = $clog2(PAGE_WORDS);                // Word index width

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ppp_pkg::ppp_state_t st;                             // Main state
    logic                strobe_prev;                    // Clock pin last cycle
    logic                wr_prev_n;                      // Write pulse last cycle
    logic                pl_prev;                        // Page latch last cycle
    logic                hv_prev;                        // High voltage last cycle
    logic [2:0]          toggles;                        // Clock pin pulses before entry
    logic [2:0]          hold_cnt;                       // Entry stability counter
    logic [7:0]          cmd;                            // Loaded command
    logic [7:0]          addr_lo;                        // Address low byte
    logic [7:0]          addr_hi;                        // Address high byte
    logic [7:0]          data_lo;                        // Data low byte
    logic [7:0]          data_hi;                        // Data high byte
    ppp_pkg::ppp_op_t    op;                             // Current array operation
    logic                start;                          // Start pulse to the arrays
    logic [7:0]          dout;                           // Bus output byte
    logic                drive_n;                        // Bus output enable, low drives
    logic                rdy;                            // Ready level
  } ppp_regs_t;

  ppp_regs_t s_r;                                        // Registered state
  ppp_regs_t s_nxt;                                      // Next state
  logic [15:0] page_buf [PAGE_WORDS];                    // Page buffer storage
  logic        pb_we;                                    // Page buffer write this cycle
  logic [WB-1:0] pb_idx;                                 // Page buffer write index
  logic [1:0]  action;                                   // Strobe action bits
  logic [3:0]  entry_pins;                               // Entry pin pattern
  logic        strobe_rise;                              // Clock pin rising edge
  logic        wr_fall;                                  // Write pulse falling edge
  logic        pl_rise;                                  // Page latch rising edge
  logic        ready_st;                                 // Accepting loads

  // ----------------------------------------------------------------
  // Edge detection on the synchronous pins
  // ----------------------------------------------------------------
  assign action      = {strobe_action_bit1, strobe_action_bit0};
  assign entry_pins  = {page_latch_strobe, strobe_action_bit1, strobe_action_bit0,
                        byte_select_first};
  assign strobe_rise = strobe_clock_pin & ~s_r.strobe_prev;   // see RULE_27
  assign wr_fall     = ~write_strobe_n & s_r.wr_prev_n;
  assign pl_rise     = page_latch_strobe & ~s_r.pl_prev;
  assign ready_st    = (s_r.st == ppp_pkg::ST_READY);
  // Word index from the low address bits, page from the rest
  assign pb_idx      = s_r.addr_lo[WB-1:0];                   // see RULE_22
  assign pb_we       = ready_st & pl_rise & byte_select_first; // see RULE_21

  // ----------------------------------------------------------------
  // Next state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt             = s_r;
    s_nxt.strobe_prev = strobe_clock_pin;
    s_nxt.wr_prev_n   = write_strobe_n;
    s_nxt.pl_prev     = page_latch_strobe;
    s_nxt.hv_prev     = prog_voltage_high;
    s_nxt.start       = 1'b0;
    unique case (s_r.st)
      // Out of programming mode: count clock pin pulses under low reset
      ppp_pkg::ST_OFF:
      begin
        if (strobe_rise && !prog_voltage_high && s_r.toggles != ppp_pkg::MIN_STROBE_TOGGLES)
          s_nxt.toggles = s_r.toggles + 3'h1;                 // see RULE_06
        if (prog_voltage_high && !s_r.hv_prev)
        begin
          s_nxt.hold_cnt = 3'h0;
          // Entry pattern must be zero at the high voltage edge
          if (s_r.toggles == ppp_pkg::MIN_STROBE_TOGGLES &&
              entry_pins == ppp_pkg::ENTRY_PINS_OK)           // see RULE_05
            s_nxt.st = ppp_pkg::ST_ENTRY;
          else
            s_nxt.st = ppp_pkg::ST_FAIL;
        end
      end
      // Entry pins must hold still for the stability time
      ppp_pkg::ST_ENTRY:
      begin
        if (entry_pins != ppp_pkg::ENTRY_PINS_OK)
          s_nxt.st = ppp_pkg::ST_FAIL;                        // see RULE_07
        else if (s_r.hold_cnt == ppp_pkg::ENTRY_CNT_LAST)
          s_nxt.st = ppp_pkg::ST_READY;
        else
          s_nxt.hold_cnt = s_r.hold_cnt + 3'h1;
      end
      // Failed entry: wait for the high voltage to go away
      ppp_pkg::ST_FAIL:
      begin
        s_nxt.st = ppp_pkg::ST_FAIL;
      end
      // Programming mode, accepting loads and write pulses
      ppp_pkg::ST_READY:
      begin
        // Loads taken on the clock pin rising edge
        if (strobe_rise)
        begin
          unique case (action)                                // see RULE_08
            ppp_pkg::ACT_ADDR:
            begin
              if (byte_select_first)                          // see RULE_09
                s_nxt.addr_hi = data_in;
              else
                s_nxt.addr_lo = data_in;
            end
            ppp_pkg::ACT_DATA:
            begin
              if (byte_select_first)                          // see RULE_03
                s_nxt.data_hi = data_in;
              else
                s_nxt.data_lo = data_in;
            end
            ppp_pkg::ACT_CMD:  s_nxt.cmd = data_in;           // see RULE_12
            ppp_pkg::ACT_IDLE: s_nxt.cmd = s_r.cmd;
          endcase
        end
        // Write pulse launches the operation of the loaded command
        if (wr_fall)
        begin
          s_nxt.op = ppp_pkg::OP_NONE;
          unique case (s_r.cmd)                               // see RULE_10
            ppp_pkg::CMD_CHIP_ERASE: s_nxt.op = ppp_pkg::OP_ERASE_FLASH; // see RULE_18
            ppp_pkg::CMD_WR_FLASH:
              if (!byte_select_first) s_nxt.op = ppp_pkg::OP_PROG_FLASH; // see RULE_25
            ppp_pkg::CMD_WR_EEPROM:
              if (!byte_select_first) s_nxt.op = ppp_pkg::OP_PROG_EEPROM;
            ppp_pkg::CMD_WR_FUSE:
            begin
              if (!byte_select_second && !byte_select_first)  // see RULE_04
                s_nxt.op = ppp_pkg::OP_WR_FUSE_LOW;
              else if (!byte_select_second)
                s_nxt.op = ppp_pkg::OP_WR_FUSE_HIGH;
            end
            ppp_pkg::CMD_WR_LOCK:    s_nxt.op = ppp_pkg::OP_WR_LOCK;
            default:                 s_nxt.op = ppp_pkg::OP_NONE;
          endcase
          if (s_nxt.op != ppp_pkg::OP_NONE)
          begin
            s_nxt.start = 1'b1;
            s_nxt.st    = ppp_pkg::ST_BUSY;
          end
        end
      end
      // Operation in progress; erase walks flash, EEPROM unless preserved, then lock
      ppp_pkg::ST_BUSY:
      begin
        if (mem_done && !s_r.start)
        begin
          s_nxt.st = ppp_pkg::ST_READY;
          if (s_r.op == ppp_pkg::OP_ERASE_FLASH)              // see RULE_15
          begin
            s_nxt.op    = eeprom_preserve_fuse ? ppp_pkg::OP_ERASE_LOCK
                                               : ppp_pkg::OP_ERASE_EEPROM; // see RULE_16
            s_nxt.start = 1'b1;
            s_nxt.st    = ppp_pkg::ST_BUSY;
          end
          else if (s_r.op == ppp_pkg::OP_ERASE_EEPROM)
          begin
            s_nxt.op    = ppp_pkg::OP_ERASE_LOCK;
            s_nxt.start = 1'b1;
            s_nxt.st    = ppp_pkg::ST_BUSY;
          end
        end
      end
    endcase
    // Leaving the high voltage ends programming mode
    if (!prog_voltage_high && s_r.st != ppp_pkg::ST_OFF)
    begin
      s_nxt.st      = ppp_pkg::ST_OFF;
      s_nxt.toggles = 3'h0;
      s_nxt.start   = 1'b0;
    end
    // Bus driven only in programming mode with output enable low
    s_nxt.drive_n = ~((s_nxt.st == ppp_pkg::ST_READY || s_nxt.st == ppp_pkg::ST_BUSY) &&
                      !output_enable_n);                      // see RULE_02
    // Read byte chosen by command and byte selects
    unique case (s_r.cmd)                                     // see RULE_11
      ppp_pkg::CMD_RD_FLASH:                                  // see RULE_26
        s_nxt.dout = byte_select_first ? mem_rdata.flash_word[15:8]
                                       : mem_rdata.flash_word[7:0];
      ppp_pkg::CMD_RD_EEPROM: s_nxt.dout = mem_rdata.eeprom_byte;
      ppp_pkg::CMD_RD_SIG:
        s_nxt.dout = byte_select_first ? mem_rdata.calib_byte : mem_rdata.sig_byte;
      ppp_pkg::CMD_RD_FUSELOCK:
      begin
        unique case ({byte_select_second, byte_select_first}) // see RULE_04
          2'h0:    s_nxt.dout = mem_rdata.fuse_low;
          2'h3:    s_nxt.dout = mem_rdata.fuse_high;
          2'h1:    s_nxt.dout = mem_rdata.lock_bits;
          2'h2:    s_nxt.dout = ppp_pkg::BUS_IDLE_VAL;
        endcase
      end
      default: s_nxt.dout = ppp_pkg::BUS_IDLE_VAL;
    endcase
    s_nxt.rdy = (s_nxt.st != ppp_pkg::ST_BUSY);               // see RULE_01
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r             <= '0;
      s_r.st          <= ppp_pkg::ST_OFF;
      s_r.wr_prev_n   <= 1'b1;
      s_r.cmd         <= ppp_pkg::CMD_RESET_VAL;
      s_r.addr_lo     <= ppp_pkg::BYTE_RESET_VAL;
      s_r.addr_hi     <= ppp_pkg::BYTE_RESET_VAL;
      s_r.data_lo     <= ppp_pkg::BYTE_RESET_VAL;
      s_r.data_hi     <= ppp_pkg::BYTE_RESET_VAL;
      s_r.op          <= ppp_pkg::OP_NONE;
      s_r.dout        <= ppp_pkg::BUS_IDLE_VAL;
      s_r.drive_n     <= 1'b1;
      s_r.rdy         <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Page buffer: written by the page latch, read by the arrays
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (pb_we)
      page_buf[pb_idx] <= {s_r.data_hi, s_r.data_lo};        // see RULE_19
    pb_rd_word <= page_buf[pb_rd_idx];
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out       = s_r.dout;
  assign data_oe_n      = s_r.drive_n;
  assign ready_busy_out = s_r.rdy;
  assign prog_mode      = (s_r.st == ppp_pkg::ST_READY) || (s_r.st == ppp_pkg::ST_BUSY);
  assign mem_req.start  = s_r.start;
  assign mem_req.op     = s_r.op;
  assign mem_req.addr   = {s_r.addr_hi, s_r.addr_lo};       // see RULE_22
  assign mem_req.wdata  = s_r.data_lo;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence entry_begins;
    $rose(s_r.st == ppp_pkg::ST_ENTRY);
  endsequence
  sequence entry_quiet;
    (entry_pins == ppp_pkg::ENTRY_PINS_OK && prog_voltage_high)[*5];
  endsequence

  a_busy_on_start: assert property (s_r.start |-> !ready_busy_out ##1 !ready_busy_out) // see RULE_01
    else $error("ready not low around operation start");
  a_bus_drive_oe: assert property (!data_oe_n |-> $past(!output_enable_n) && prog_mode) // see RULE_02
    else $error("bus driven without output enable");
  a_entry_fail_pins: assert property ((s_r.st == ppp_pkg::ST_ENTRY && prog_voltage_high &&
    entry_pins != ppp_pkg::ENTRY_PINS_OK) |=> s_r.st == ppp_pkg::ST_FAIL) // see RULE_07
    else $error("entry pin change did not fail entry");
  a_entry_hold_done: assert property (entry_begins ##0 entry_quiet |=>
    s_r.st == ppp_pkg::ST_READY) // see RULE_07
    else $error("entry did not complete after hold time");
  a_addr_low_load: assert property ((ready_st && strobe_rise && action == ppp_pkg::ACT_ADDR &&
    !byte_select_first && prog_voltage_high) |=> s_r.addr_lo == $past(data_in)) // see RULE_09
    else $error("address low byte not loaded");
  a_idle_no_load: assert property ((strobe_rise && action == ppp_pkg::ACT_IDLE) |=>
    $stable(s_r.cmd) && $stable(s_r.addr_lo) && $stable(s_r.data_lo)) // see RULE_08
    else $error("idle action changed a byte");
  a_erase_order: assert property ((s_r.start && s_r.op == ppp_pkg::OP_ERASE_LOCK) |->
    $past(s_r.op) inside {ppp_pkg::OP_ERASE_FLASH, ppp_pkg::OP_ERASE_EEPROM}) // see RULE_15
    else $error("lock bits erased before memory");
  a_eeprom_preserve: assert property ((s_r.start && s_r.op == ppp_pkg::OP_ERASE_EEPROM) |->
    $past(!eeprom_preserve_fuse)) // see RULE_16
    else $error("EEPROM erased although preserved");
  a_cmd_retained: assert property ((ready_st && !(strobe_rise && action == ppp_pkg::ACT_CMD))
    |=> $stable(s_r.cmd)) // see RULE_12
    else $error("command changed without a load");

endmodule // ppp_port

// >>> bench/ppp_mem_model.sv
// Memory array stand-in that answers operation requests of the port
`timescale 1ns/100ps
module ppp_mem_model (
  input  wire logic                 core_clk,  // System clock
  input  wire logic                 reset_n,   // Asynchronous reset, active low
  input  wire ppp_pkg::ppp_memreq_t mem_req,   // Request from the port
  output logic                      mem_done,  // One-cycle finish pulse
  output ppp_pkg::ppp_rdata_t       mem_rdata  // Read data for the current address
);
  logic [3:0] wait_r;                          // Cycles left of the running operation
  // Flash high byte differs from low byte so that byte order shows
  // Every other byte has a value of its own so that a wrong read path shows
  assign mem_rdata = '{flash_word: {8'hA5 ^ mem_req.addr[7:0], mem_req.addr[7:0]},
                       eeprom_byte: 8'h11, sig_byte: 8'h22, calib_byte: 8'h33,
                       fuse_low: 8'h44, fuse_high: 8'h55, lock_bits: 8'h66};
  // Each operation takes four cycles, so busy spans several edges
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      wait_r <= 4'h0;
    else if (mem_req.start)
      wait_r <= 4'h4;
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
  assign mem_done = (wait_r == 4'h1);
endmodule // ppp_mem_model

// >>> bench/testbench.sv
// Self-checking testbench of the parallel programming port
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, hv = 1'b0, sck = 1'b0, oe_n = 1'b1, wr_n = 1'b1;
  logic pl = 1'b0, a0 = 1'b0, a1 = 1'b0, bs1 = 1'b0, bs2 = 1'b0, pres = 1'b0, done, rdy, pm;
  logic [7:0] din = 8'h00, dout;
  logic       doe_n;
  logic [5:0] pb_idx = 6'h00;                  // Page buffer read index
  logic [15:0] pbw;                            // Page buffer word read back
  ppp_pkg::ppp_rdata_t  rdata;                 // Array read data
  ppp_pkg::ppp_memreq_t mreq;                  // Array request
  ppp_pkg::ppp_op_t     ops[$];                // Operations started, in order
  int fail_count = 0, check_count = 0;
  always #10 core_clk = ~core_clk;
  // Record every operation start
  always @(posedge core_clk)
    if (mreq.start === 1'b1)
      ops.push_back(mreq.op);
  ppp_port ppp_port_inst (.core_clk(core_clk), .reset_n(reset_n), .prog_voltage_high(hv),
    .strobe_clock_pin(sck), .output_enable_n(oe_n), .write_strobe_n(wr_n),
    .page_latch_strobe(pl), .strobe_action_bit0(a0), .strobe_action_bit1(a1),
    .byte_select_first(bs1), .byte_select_second(bs2), .data_in(din), .data_out(dout),
    .data_oe_n(doe_n), .ready_busy_out(rdy), .prog_mode(pm), .eeprom_preserve_fuse(pres),
    .mem_rdata(rdata), .mem_req(mreq), .mem_done(done), .pb_rd_idx(pb_idx), .pb_rd_word(pbw));
  ppp_mem_model ppp_mem_model_inst (.core_clk(core_clk), .reset_n(reset_n), .mem_req(mreq),
    .mem_done(done), .mem_rdata(rdata));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe load: action, first select and byte held around the pulse
  task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] d);
    @(posedge core_clk);
    {a1, a0} <= act;
    bs1 <= b1;
    din <= d;
    sck <= 1'b1;
    cyc(2);
    sck <= 1'b0;
    {a1, a0} <= 2'h0;
    cyc(2);
  endtask
  // Bounded wait for ready, a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 200)
    begin
      fail_count++;
      results();
    end
  endtask
  // Power-on entry, a pin change in the hold time must refuse entry
  task automatic t_entry(input logic bad);
    @(posedge core_clk);
    hv <= 1'b0;
    repeat (6)
    begin
      cyc(2);
      sck <= 1'b1;
      cyc(2);
      sck <= 1'b0;
    end
    cyc(3);
    hv <= 1'b1;
    cyc(2);
    pl <= bad;
    cyc(1);
    pl <= 1'b0;
    cyc(8);
    #1 chk(16'(pm), 16'(!bad));
    chk(16'(rdy), 16'h0001);
    $display("entry test done");
  endtask
  // Address bytes by first select, idle action ignored, data byte stored
  task automatic t_loads();
    load(ppp_pkg::ACT_ADDR, 1'b0, 8'h3A);
    load(ppp_pkg::ACT_ADDR, 1'b1, 8'h01);
    load(ppp_pkg::ACT_IDLE, 1'b0, 8'hEE);
    load(ppp_pkg::ACT_DATA, 1'b0, 8'h5C);
    chk(mreq.addr, 16'h013A);
    chk(16'(mreq.wdata), 16'h005C);
    $display("load test done");
  endtask
  // Write command with write pulse: busy, then the count, first and last of the operations
  task automatic t_wcmd(input logic [7:0] cmd, input logic b1, input ppp_pkg::ppp_op_t f,
                        input ppp_pkg::ppp_op_t l, input int n);
    ops = {};
    load(ppp_pkg::ACT_CMD, 1'b0, cmd);
    @(posedge core_clk);
    bs1 <= b1;
    wr_n <= 1'b0;
    cyc(2);
    wr_n <= 1'b1;
    #1 chk(16'(rdy), 16'h0000);
    wait_rdy();
    chk(16'(ops.size()), 16'(n));
    chk(16'(ops[0]), 16'(f));
    chk(16'(ops[ops.size() - 1]), 16'(l));
    $display("write command test done");
  endtask
  // Page latch stores data bytes at the word index of the low address
  task automatic t_page();
    load(ppp_pkg::ACT_ADDR, 1'b0, 8'h45);
    load(ppp_pkg::ACT_DATA, 1'b0, 8'h34);
    load(ppp_pkg::ACT_DATA, 1'b1, 8'h12);
    @(posedge core_clk);
    pl <= 1'b1;
    pb_idx <= 6'h05;
    cyc(2);
    pl <= 1'b0;
    cyc(2);
    #1 chk(pbw, 16'h1234);
    $display("page test done");
  endtask
  // Flash read: bus driven only with output enable, byte by first select
  task automatic t_read();
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
    load(ppp_pkg::ACT_ADDR, 1'b0, 8'h3A);
    chk(16'(doe_n), 16'h0001);
    oe_n <= 1'b0;
    cyc(2);
    #1 chk(16'(doe_n), 16'h0000);
    chk(16'(dout), 16'h003A);
    @(posedge core_clk);
    bs1 <= 1'b1;
    cyc(2);
    #1 chk(16'(dout), 16'h009F);
    // Fuse and lock read: both selects pick the byte
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSELOCK);
    chk(16'(dout), 16'h0044);
    bs2 <= 1'b1;
    bs1 <= 1'b1;
    cyc(2);
    #1 chk(16'(dout), 16'h0055);
    @(posedge core_clk);
    bs2 <= 1'b0;
    cyc(2);
    #1 chk(16'(dout), 16'h0066);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
    chk(16'(dout), 16'h0022);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEPROM);
    chk(16'(dout), 16'h0011);
    oe_n <= 1'b1;
    cyc(2);
    #1 chk(16'(doe_n), 16'h0001);
    $display("read test done");
  endtask
  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    t_entry(1'b1);
    t_entry(1'b0);
    t_loads();
    t_wcmd(ppp_pkg::CMD_CHIP_ERASE, 1'b0, ppp_pkg::OP_ERASE_FLASH, ppp_pkg::OP_ERASE_LOCK, 3);
    @(posedge core_clk);
    pres <= 1'b1;
    t_wcmd(ppp_pkg::CMD_CHIP_ERASE, 1'b0, ppp_pkg::OP_ERASE_FLASH, ppp_pkg::OP_ERASE_LOCK, 2);
    t_page();
    t_wcmd(ppp_pkg::CMD_WR_FLASH, 1'b0, ppp_pkg::OP_PROG_FLASH, ppp_pkg::OP_PROG_FLASH, 1);
    t_wcmd(ppp_pkg::CMD_WR_EEPROM, 1'b0, ppp_pkg::OP_PROG_EEPROM, ppp_pkg::OP_PROG_EEPROM, 1);
    t_wcmd(ppp_pkg::CMD_WR_FUSE, 1'b0, ppp_pkg::OP_WR_FUSE_LOW, ppp_pkg::OP_WR_FUSE_LOW, 1);
    t_wcmd(ppp_pkg::CMD_WR_FUSE, 1'b1, ppp_pkg::OP_WR_FUSE_HIGH, ppp_pkg::OP_WR_FUSE_HIGH, 1);
    t_wcmd(ppp_pkg::CMD_WR_LOCK, 1'b0, ppp_pkg::OP_WR_LOCK, ppp_pkg::OP_WR_LOCK, 1);
    t_read();
    results();
  end
endmodule // testbench
